// ---- src/mbs_reload_ctrl.sv ----
/*
  Reload controller: takes a reload order over APB, selects an image,
  checks its first byte for the user marker and pulses the reload pin.
  Assumes the memory end on lk, APB on REF_CLK, USER_RESET from the
  same clock domain and the memory data bus from outside it.
*/
// The APB register port and the register offsets are this design's own decisions.
// Operation
// - Memory stores four images, select 0 to 3
// - Enable low: select pins choose the image
// - Enable high: internal bits choose the image
// - Choice sampled once at power-up
// - Resampled on trigger rise while chip enabled
// - Undriven select inputs read as one
// - Chosen image output as byte or bit
// - Controller holds external choice enable low
// - Memory chip enable stays tied low
// - Controller drives the sample trigger
// - Controller drives reload request through output
// - Controller drives selects and output enable
// - Watch data bus; user reset clears sequencer
// - Image one should hold fail-safe image
// - Selects stable, trigger low, 300 ns first
// - After trigger, reload request low 300 ns
// - No marker in first byte: halt
// - Output enable low in normal operation
`timescale 1ns/10ps
module mbs_reload_ctrl
  import mbs_pkg::*;
#(
  parameter logic [7:0] MARKER = 8'h5A
)
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic USER_RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [PADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  mbs_link_if.ctrl lk
);

  typedef struct packed {
    mbs_state_t st;
    logic [TMR_W-1:0] tmr;
    logic pend;
    logic [1:0] img_cfg;
    logic [1:0] choice;
    logic trig;
    logic oe;
    logic rl_n;
    logic [1:0] drv;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] d3;
    logic [7:0] df;
    logic [7:0] last;
    logic [INT_W-1:0] ist;
    logic [INT_W-1:0] imask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mbs_ctrl_st_t;

  mbs_ctrl_st_t q, n;
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic [31:0] rd;
  logic [INT_W-1:0] ev;
  logic [INT_W-1:0] clr;
  logic tmr_done;

  // ***************************************************************
  // Register read decode
  // ***************************************************************
  // Read data and unmapped detection for the current address
  always_comb
  begin
    rd = 32'h0000_0000;
    mapped = 1'h1;
    case (PADDR)
      REG_CTRL: rd[CTRL_IMG_LSB +: SEL_W] = q.img_cfg;
      REG_STATUS:
      begin
        rd[STAT_STATE_LSB +: 3] = q.st;
        rd[STAT_PEND_BIT] = q.pend;
        rd[STAT_BYTE_LSB +: DATA_W] = q.last;
      end
      REG_INT_STAT: rd[INT_W-1:0] = q.ist;
      REG_INT_MASK: rd[INT_W-1:0] = q.imask;
      default: mapped = 1'h0;
    endcase
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  // Data bus filter, register writes, sequencer and interrupt
  always_comb
  begin
    n = q;
    ev = '0;
    clr = '0;
    tmr_done = (q.tmr == TMR_ZERO);
    // Memory data bus comes from outside, three stages
    n.d1 = lk.data;
    n.d2 = q.d1;
    n.d3 = q.d2;
    n.df = mbs_agree(q.d2, q.d3, q.df);
    // Select pins driven from the first edge after reset
    n.drv = '1;

    // APB: ready and answer prepared in the setup cycle
    setup = PSEL & ~PENABLE;
    access = PSEL & PENABLE & q.pready;
    wr = access & PWRITE & ~q.pslverr;
    n.pready = setup;
    n.pslverr = setup & ~mapped;
    n.prdata = (setup && !PWRITE) ? rd : 32'h0000_0000;
    if (wr && PADDR == REG_CTRL)
    begin
      n.img_cfg = PWDATA[CTRL_IMG_LSB +: SEL_W];
      if (PWDATA[CTRL_GO_BIT])
      begin
        n.pend = 1'h1;
      end
    end
    if (wr && PADDR == REG_INT_STAT)
    begin
      clr = PWDATA[INT_W-1:0];
    end
    if (wr && PADDR == REG_INT_MASK)
    begin
      n.imask = PWDATA[INT_W-1:0];
    end

    // Sequencer, every wait a down counter
    if (!tmr_done)
    begin
      n.tmr = q.tmr - 8'h01;
    end
    case (q.st)
      ST_IDLE:
      begin
        n.oe = 1'h0;
        n.rl_n = 1'h1;
        if (q.pend)
        begin
          n.pend = 1'h0;
          n.choice = q.img_cfg;
          n.trig = 1'h0;
          n.tmr = SEL_SETUP_CNT;
          n.st = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        if (tmr_done)
        begin
          // Rising trigger samples the selects, enable shows byte 0
          n.trig = 1'h1;
          n.oe = 1'h1;
          n.tmr = DATA_VALID_CNT;
          n.st = ST_SAMPLE;
        end
      end
      ST_SAMPLE:
        if (tmr_done)
          n.st = ST_CHECK;
      ST_CHECK:
      begin
        n.last = q.df;
        n.trig = 1'h0;
        n.oe = 1'h0;
        if (q.df == MARKER)
        begin
          n.tmr = SEL_SETUP_CNT;
          n.st = ST_RESETUP;
        end
        else
        begin
          ev[INT_MISS_BIT] = 1'h1;
          n.st = ST_HALT;
        end
      end
      ST_RESETUP:
      begin
        if (tmr_done)
        begin
          n.trig = 1'h1;
          n.rl_n = 1'h0;
          n.tmr = RELOAD_LOW_CNT;
          n.st = ST_RELOAD;
        end
      end
      ST_RELOAD:
      begin
        if (tmr_done)
        begin
          n.rl_n = 1'h1;
          ev[INT_RELOAD_BIT] = 1'h1;
          n.st = ST_IDLE;
        end
      end
      ST_HALT: n.st = ST_HALT;
      default: n.st = ST_IDLE;
    endcase

    // User reset clears sequencer and any pending order
    if (USER_RESET)
    begin
      n.st = ST_IDLE;
      n.pend = 1'h0;
      n.tmr = TMR_ZERO;
      n.trig = 1'h0;
      n.oe = 1'h0;
      n.rl_n = 1'h1;
    end

    // Sticky events, a new event beats a clear
    n.ist = (q.ist & ~clr) | ev;
    n.irq = |(n.ist & n.imask);
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  // Reset leaves reload request high and the trigger low
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.rl_n <= 1'h1;
      q.img_cfg <= IMG_CFG_RST;
    end
    else
    begin
      q <= n;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // All outputs straight from the state register, except the choice enable, tied low
  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign IRQ = q.irq;
  assign lk.choice_o = q.choice;
  assign lk.choice_oe = q.drv;
  assign lk.external_choice_enable = 1'h0;
  assign lk.sample_trigger = q.trig;
  assign lk.oe_reset = q.oe;
  assign lk.reload_request_n = q.rl_n;

endmodule // mbs_reload_ctrl

// ---- inc/mbs_pkg.sv ----
/*
  Shared constants, field layouts, state codes and helpers for the
  image select memory and its reload controller.
  Assumes a single 250 MHz clock on both ends.
*/
package mbs_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int T_SEL_SETUP_NS = 300;
  localparam int T_DATA_VALID_NS = 300;
  localparam int T_RELOAD_LOW_NS = 300;

  // Least time to whole cycles, rounded up, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SEL_SETUP_CYC = ns_to_cyc(T_SEL_SETUP_NS);
  localparam int DATA_VALID_CYC = ns_to_cyc(T_DATA_VALID_NS);
  localparam int RELOAD_LOW_CYC = ns_to_cyc(T_RELOAD_LOW_NS);
  localparam int TMR_W = 8;
  // Timers load N-1 and count to zero, giving N cycles
  localparam logic [TMR_W-1:0] SEL_SETUP_CNT = TMR_W'(SEL_SETUP_CYC - 1);
  localparam logic [TMR_W-1:0] DATA_VALID_CNT = TMR_W'(DATA_VALID_CYC - 1);
  localparam logic [TMR_W-1:0] RELOAD_LOW_CNT = TMR_W'(RELOAD_LOW_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;

  // ***************************************************************
  // Widths and memory layout
  // ***************************************************************
  localparam int DATA_W = 8;
  localparam int SEL_W = 2;
  localparam int N_IMAGES = 4;
  localparam logic [1:0] PWRUP_CYC = 2'h3;
  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic [SEL_W-1:0] SEL_PULLUP = 2'h3;

  // Device pin vector positions after the input filter
  localparam int PIN_SEL_LSB = 0;
  localparam int PIN_TRIG = 2;
  localparam int PIN_OE = 3;
  localparam int PIN_ECE = 4;

  // ***************************************************************
  // Controller registers (APB byte addresses)
  // ***************************************************************
  localparam int PADDR_W = 8;
  localparam logic [PADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [PADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [PADDR_W-1:0] REG_INT_STAT = 8'h08;
  localparam logic [PADDR_W-1:0] REG_INT_MASK = 8'h0C;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_IMG_LSB = 1;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_PEND_BIT = 3;
  localparam int STAT_BYTE_LSB = 8;
  localparam int INT_W = 2;
  localparam int INT_MISS_BIT = 0;
  localparam int INT_RELOAD_BIT = 1;
  localparam logic [SEL_W-1:0] IMG_CFG_RST = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_SAMPLE, ST_CHECK, ST_RESETUP, ST_RELOAD, ST_HALT
  } mbs_state_t;

  // Pin filter: take a bit once stages two and three agree
  function automatic logic [7:0] mbs_agree(input logic [7:0] s2,
                                           input logic [7:0] s3,
                                           input logic [7:0] f);
    return (s2 & ~(s2 ^ s3)) | (f & (s2 ^ s3));
  endfunction

endpackage

// ---- inc/mbs_link_if.sv ----
/*
  Pins between the image select memory and the reload controller.
  Assumes both ends share REF_CLK; undriven select pins pull up to one.
*/
`timescale 1ns/10ps
interface mbs_link_if;
  logic [1:0] choice_o;
  logic [1:0] choice_oe;
  logic [1:0] choice_pin;
  logic external_choice_enable;
  logic sample_trigger;
  logic oe_reset;
  logic reload_request_n;
  logic [7:0] data;

  // Pull-up on each select line left undriven
  genvar i;
  for (i = 0; i < 2; i++)
  begin : g_pull
    assign choice_pin[i] = choice_oe[i] ? choice_o[i] : 1'h1;
  end

  modport ctrl (output choice_o, output choice_oe,
                output external_choice_enable, output sample_trigger,
                output oe_reset, output reload_request_n, input data);
  modport mem (input choice_pin, input external_choice_enable,
               input sample_trigger, input oe_reset, output data);
endinterface

// ---- src/mbs_image_store.sv ----
/*
  Configuration memory end: four stored images, image choice sampling
  and byte or bit output of the chosen image.
  Assumes link pins arrive unsynchronised and STEP comes from REF_CLK.
*/
`timescale 1ns/10ps
module mbs_image_store
  import mbs_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AW = $clog2(DEPTH)
)
(
  input wire logic REF_CLK,
  input wire logic RST,
  mbs_link_if.mem lk,
  input wire logic CHIP_EN_N,
  input wire logic [1:0] INTERNAL_CHOICE,
  input wire logic SERIAL_MODE,
  input wire logic STEP,
  input wire logic PRG_WE,
  input wire logic [1:0] PRG_IMAGE,
  input wire logic [AW-1:0] PRG_ADDR,
  input wire logic [7:0] PRG_DATA,
  output logic [1:0] SELECTED_IMAGE,
  output logic BOOTED
);

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] pf;
    logic [1:0] boot;
    logic booted;
    logic [1:0] sel;
    logic [AW-1:0] ptr;
    logic [2:0] bitc;
    logic [7:0] dout;
  } mbs_mem_st_t;

  mbs_mem_st_t q, n;
  logic [7:0] img_mem [N_IMAGES][DEPTH];
  logic [7:0] pins;
  logic [1:0] choice_now;
  logic [7:0] cur_byte;
  logic rise;

  // ***************************************************************
  // Image storage
  // ***************************************************************
  // Loader port fills any image at any address
  always_ff @(posedge REF_CLK)
  begin
    if (PRG_WE)
    begin
      img_mem[PRG_IMAGE][PRG_ADDR] <= PRG_DATA;
    end
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  // Filter pins, sample the choice, stream the chosen image
  always_comb
  begin
    n = q;
    pins = {3'h0, lk.external_choice_enable, lk.oe_reset,
            lk.sample_trigger, lk.choice_pin};
    n.s1 = pins;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.pf = mbs_agree(q.s2, q.s3, q.pf);
    rise = n.pf[PIN_TRIG] & ~q.pf[PIN_TRIG];
    // Pins or programmed bits, by the enable level
    choice_now = q.pf[PIN_ECE] ? INTERNAL_CHOICE
                               : q.pf[PIN_SEL_LSB +: SEL_W];
    if (!q.booted)
    begin
      n.boot = q.boot + 2'h1;
      if (q.boot == PWRUP_CYC)
      begin
        n.sel = choice_now;
        n.booted = 1'h1;
      end
    end
    else if (rise && !CHIP_EN_N)
    begin
      n.sel = choice_now;
    end
    cur_byte = img_mem[q.sel][q.ptr];
    if (!q.pf[PIN_OE])
    begin
      n.ptr = '0;
      n.bitc = 3'h0;
      n.dout = 8'h00;
    end
    else
    begin
      // Parallel byte or serial bit, MSB first
      n.dout = SERIAL_MODE ? {7'h00, cur_byte[BIT_MSB - q.bitc]}
                           : cur_byte;
      if (STEP)
      begin
        if (!SERIAL_MODE || q.bitc == BIT_MSB)
        begin
          n.ptr = q.ptr + AW'(1);
        end
        n.bitc = SERIAL_MODE ? q.bitc + 3'h1 : 3'h0;
      end
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  // Power-up clears all control state
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  assign lk.data = q.dout;
  assign SELECTED_IMAGE = q.sel;
  assign BOOTED = q.booted;

endmodule // mbs_image_store

// ---- verif/mbs_link_props.sv ----
/*
  Assertions on the link between reload controller and memory end.
  Assumes instantiation in tb_top beside the link, one clock domain.
*/
`timescale 1ns/10ps
module mbs_link_props
  import mbs_pkg::*;
#(
  parameter logic [7:0] MARKER = 8'h5A
)
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic USER_RESET,
  input wire logic [1:0] choice_o,
  input wire logic [1:0] choice_oe,
  input wire logic external_choice_enable,
  input wire logic sample_trigger,
  input wire logic oe_reset,
  input wire logic reload_request_n,
  input wire logic [7:0] data
);
  localparam int SETUP_MIN = 74;
  logic [7:0] lo_q;
  logic [7:0] st_q;
  logic [1:0] ch_q;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // Count low pulse cycles and stable select cycles with trigger low
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      lo_q <= 8'h00;
      st_q <= 8'h00;
      ch_q <= 2'h0;
    end
    else
    begin
      lo_q <= reload_request_n ? 8'h00 : lo_q + 8'h01;
      st_q <= (sample_trigger || choice_o != ch_q) ? 8'h00 :
              (st_q == 8'hFF) ? st_q : st_q + 8'h01;
      ch_q <= choice_o;
    end
  end

  // ****************************************
  // Link properties
  // ****************************************
  chk_ece_held_low: assert property (
    !external_choice_enable)
    else $error("choice enable not low");
  chk_sel_driven: assert property (
    !$past(RST) |-> choice_oe == 2'h3)
    else $error("select pins not driven");
  chk_setup_window: assert property (
    $rose(sample_trigger) |-> st_q >= SETUP_MIN)
    else $error("select setup too short");
  chk_pulse_cause: assert property (
    $fell(reload_request_n) |-> $rose(sample_trigger))
    else $error("reload pulse without trigger rise");
  chk_pulse_max: assert property (
    !reload_request_n |-> lo_q < RELOAD_LOW_CYC)
    else $error("reload pulse too long");
  chk_pulse_len: assert property (
    $rose(reload_request_n) |-> lo_q == RELOAD_LOW_CYC)
    else $error("reload pulse wrong length");
  chk_oe_with_trig: assert property (
    $rose(oe_reset) |-> $rose(sample_trigger))
    else $error("output enable rose alone");
  chk_oe_window: assert property (
    $rose(oe_reset) |-> ##76 $fell(oe_reset))
    else $error("output enable window wrong");
  chk_marker_go: assert property (
    $fell(oe_reset) && $past(data, 2) == MARKER
    |-> ##75 $fell(reload_request_n))
    else $error("no reload after marker");
  chk_marker_halt: assert property (
    $fell(oe_reset) && $past(data, 2) != MARKER
    |-> ##75 (reload_request_n && !sample_trigger))
    else $error("reload without marker");
  chk_user_clear: assert property (
    USER_RESET |=> reload_request_n && !oe_reset)
    else $error("user reset left pins active");
endmodule // mbs_link_props

// ---- verif/tb_top.sv ----
/*
  Self-checking bench: controller and memory end joined by the link.
  Assumes nothing outside; makes clock, reset and APB traffic itself.
*/
`timescale 1ns/10ps
module tb_top;
  import mbs_pkg::*;
  localparam logic [7:0] MARK = 8'h5A;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic user_rst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic prg_we = 1'b0;
  logic [1:0] prg_image = 2'h0;
  logic [7:0] prg_data = 8'h00;
  logic serial = 1'b0;
  logic step = 1'b0;
  logic [1:0] sel_img;
  logic booted;
  logic [31:0] rdata;
  logic rerr;
  logic rl_prev = 1'b1;
  int n_pulse = 0;
  int cyc = 0;
  int fail_count = 0;
  int n_checks = 0;

  mbs_link_if lk();
  mbs_reload_ctrl #(.MARKER(MARK)) u_mbs_reload_ctrl (.REF_CLK(ref_clk),
    .RST(rst), .USER_RESET(user_rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .lk(lk.ctrl));
  mbs_image_store u_mbs_image_store (.REF_CLK(ref_clk), .RST(rst),
    .lk(lk.mem), .CHIP_EN_N(1'b0), .INTERNAL_CHOICE(2'h0),
    .SERIAL_MODE(serial), .STEP(step), .PRG_WE(prg_we),
    .PRG_IMAGE(prg_image), .PRG_ADDR(8'h00), .PRG_DATA(prg_data),
    .SELECTED_IMAGE(sel_img), .BOOTED(booted));
  mbs_link_props #(.MARKER(MARK)) u_mbs_link_props (.REF_CLK(ref_clk),
    .RST(rst), .USER_RESET(user_rst), .choice_o(lk.choice_o),
    .choice_oe(lk.choice_oe),
    .external_choice_enable(lk.external_choice_enable),
    .sample_trigger(lk.sample_trigger), .oe_reset(lk.oe_reset),
    .reload_request_n(lk.reload_request_n), .data(lk.data));

  // Clock, timeout and reload pulse counter
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (rl_prev && !lk.reload_request_n)
      n_pulse = n_pulse + 1;
    rl_prev = lk.reload_request_n;
    if (cyc == 20000)
    begin
      fail_count = fail_count + 1;
      finish_test();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic finish_test();
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h want %h", $time, got, exp);
      fail_count = fail_count + 1;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_rest();
    logic done;
    done = 1'b0;
    repeat (4) @(posedge ref_clk);
    while (!done)
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      done = (rdata[2:0] === 3'h0) || (rdata[2:0] === 3'h6);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values();
    chk({31'h0, booted}, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rdata, 32'h2);
    apb(1'b0, REG_INT_MASK, 32'h0);
    chk(rdata, 32'h0);
  endtask

  task automatic t_images();
    int n0;
    for (int k = 0; k < 4; k++)
    begin
      prg_we <= 1'b1;
      prg_image <= k[1:0];
      prg_data <= (k == 2) ? 8'hA5 : MARK;
      @(posedge ref_clk);
    end
    prg_we <= 1'b0;
    @(posedge ref_clk);
    for (int k = 3; k >= 0; k--)
    begin
      if (k != 2)
      begin
        n0 = n_pulse;
        apb(1'b1, REG_CTRL, {29'h0, k[1:0], 1'b1});
        wait_rest();
        chk({30'h0, sel_img}, k);
        chk({24'h0, rdata[15:8]}, {24'h0, MARK});
        chk(rdata[3:0], 32'h0);
        chk(n_pulse, n0 + 1);
      end
    end
  endtask

  task automatic t_no_marker();
    int n0;
    n0 = n_pulse;
    apb(1'b1, REG_CTRL, 32'h5);
    wait_rest();
    chk(rdata[15:0], 32'hA506);
    apb(1'b1, REG_CTRL, 32'h5);
    repeat (80) @(posedge ref_clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rdata[3:0], 32'hE);
    chk(n_pulse, n0);
    user_rst <= 1'b1;
    @(posedge ref_clk);
    user_rst <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rdata[3:0], 32'h0);
  endtask

  // Serial stream of image 0, MSB first, one bit per step
  task automatic t_serial();
    serial <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h1);
    while (lk.oe_reset !== 1'b1)
      @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    for (int b = 7; b >= 0; b--)
    begin
      chk({24'h0, lk.data}, {31'h0, MARK[b]});
      if (b > 0)
      begin
        step <= 1'b1;
        @(posedge ref_clk);
        step <= 1'b0;
        repeat (2) @(posedge ref_clk);
      end
    end
    wait_rest();
    chk(rdata[15:0], 32'h0006);
    serial <= 1'b0;
    user_rst <= 1'b1;
    @(posedge ref_clk);
    user_rst <= 1'b0;
  endtask

  task automatic t_irq_and_errors();
    apb(1'b0, REG_INT_STAT, 32'h0);
    chk(rdata, 32'h3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, REG_INT_MASK, 32'h2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, REG_INT_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, REG_INT_STAT, 32'h0);
    chk(rdata, 32'h1);
    apb(1'b1, 8'h10, 32'hFFFF);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk({rdata[30:0], rerr}, 32'h1);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    t_reset_values();
    t_images();
    t_no_marker();
    t_serial();
    t_irq_and_errors();
    finish_test();
  end
endmodule // tb_top
